//--- rtl/tfmt_defs.svh
// constants for the tape format read/write block
// assumes inclusion by the core module only
`ifndef TFMT_DEFS_SVH
`define TFMT_DEFS_SVH
// register offsets (word addresses, one word each)
`define TFMT_A_WDATA 4'h0
`define TFMT_A_WPAR 4'h1
`define TFMT_A_UNIT 4'h2
`define TFMT_A_CMD 4'h3
`define TFMT_A_CTRL 4'h4
`define TFMT_A_RDATA 4'h5
`define TFMT_A_STAT 4'h6
`define TFMT_A_RDIN 4'h7
`define TFMT_A_CHK 4'h8
`define TFMT_A_PRESET 4'h9
// ctrl bits
`define TFMT_C_WRITE_GATE_ENABLE 0
`define TFMT_C_RGATE 1
`define TFMT_C_PE 2
// timing
`define TFMT_CLK_HZ 25000000
`define TFMT_SRC_HZ 7200000
`define TFMT_LOCK_ENABLE_TRANS 4'h4
`define TFMT_LOCKED_WAIT 16'h0400
`define TFMT_NODATA_WAIT 16'h0800
`define TFMT_PRESET_RST 16'h0009
`define TFMT_DIV24 5'h17
`define TFMT_DIV24_HALF 5'h0B
`endif

//--- rtl/tfmt_pkg.sv
// types for the tape format read/write block
// assumes the defs header is included alongside
package tfmt_pkg;
  typedef enum logic [2:0] {
    TFMT_S0 = 3'b001,
    TFMT_S1 = 3'b010,
    TFMT_S2 = 3'b100
  } tfmt_chan_t;
  typedef struct packed {
    logic single_drop;
    logic multi_drop;
    logic all_drop;
    logic file_mark;
    logic id_burst;
  } tfmt_pe_stat_t;
  typedef struct packed {
    logic gate;
    logic par;
    logic [7:0] data;
  } tfmt_wchar_t;
endpackage : tfmt_pkg

//--- rtl/tfmt_core.sv
// tape-side datapath: write char register, strobes, read capture, PE
// recovery, all reached from the microprogram over Avalon-MM.
// assumes read head lines asynchronous; single 25 MHz clock.
//
// Summary of operation
// (R1) nine-bit write register: byte plus parity
// (R2) parity loads with data from bus
// (R3) parity also loadable directly from bus
// (R4) unit register decodes to one-hot selects
// (R5) motion commands from microprogram-only register
// (R6) NRZ read: nine bits, upper zero
// (R7) PE read: parity replicated in upper byte
// (R8) read parity checked by same generator
// (R9) 800/1600 char clocks from preset divider
// (R10) timer always; write strobe only when gated
// (R11) timer ticks from 800 clock
// (R12) read gate starts watching ch2, parity
// (R13) transitions give lock enable, then locked
// (R14) unlocked channel drops out at locked
// (R15) no data when both channels idle
// (R16) state zero: falling edge is zero
// (R17) no zero by locked: drop, shift stream
// (R18) state one waits one; two shifts
// (R19) after dropout force-feed until disabled
// (R20) clock follows write, parity, then ch2
// (R21) shared divide-by-24 recovered clock
// (R22) dropout pattern table gives PE status
// (R23) reset clears gates, states, lock, drops
//
// The register addresses and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/1ps
`include "tfmt_defs.svh"
module tfmt_core
  import tfmt_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic [8:0] read_head,
  output logic [7:0] drive_select,
  output logic [7:0] drive_command,
  output tfmt_wchar_t write_char,
  output logic [8:0] shift_in,
  output logic write_strobe,
  output logic timer_tick
);
  // =====================================================
  // helpers
  function automatic logic par9(input logic [8:0] v);
    par9 = ~(^v);
  endfunction : par9

  // =====================================================
  // bus slave: one wait state, answer on second edge
  logic busy;
  logic acc;
  assign acc = (read | write) & busy;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
    end else begin
      busy <= (read | write) & ~busy;
    end
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= ~((read | write) & ~busy);
    end
  end

  // =====================================================
  // write side registers
  logic [2:0] ctrl;
  logic [2:0] unit;
  logic [15:0] preset;
  logic wr_data;
  assign wr_data = acc & write & (address == `TFMT_A_WDATA);
  // (R1) nine-bit character register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      write_char <= '0;
    end else begin
      write_char.gate <= ctrl[`TFMT_C_WRITE_GATE_ENABLE];
      if (wr_data) begin
        write_char.data <= writedata[7:0];
      end
      // (R2) generated parity at data load
      if (wr_data) begin
        write_char.par <= par9(writedata[8:0]);
      // (R3) raw parity for uncomputed characters
      end else if (acc & write & (address == `TFMT_A_WPAR)) begin
        write_char.par <= writedata[0];
      end
    end
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      unit <= 3'h0;
      drive_command <= 8'h00;
      ctrl <= 3'h0;
      preset <= `TFMT_PRESET_RST;
    end else if (acc & write) begin
      if (address == `TFMT_A_UNIT) unit <= writedata[2:0];
      // (R5) motion commands only from microprogram
      if (address == `TFMT_A_CMD) drive_command <= writedata[7:0];
      // (R23) gates clear on reset
      if (address == `TFMT_A_CTRL) ctrl <= writedata[2:0];
      if (address == `TFMT_A_PRESET) preset <= writedata[15:0];
    end
  end
  // (R4) one-hot unit select
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      drive_select <= 8'h00;
    end else begin
      drive_select <= 8'h01 << unit;
    end
  end

  // =====================================================
  // character clocks: 7.2 MHz source derived by accumulator
  logic [24:0] src_acc;
  logic src_tick;
  logic [15:0] div;
  logic c1600;
  logic c800;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      src_acc <= 25'h0;
      src_tick <= 1'b0;
    end else if (src_acc >= 25'(`TFMT_CLK_HZ - `TFMT_SRC_HZ)) begin
      src_acc <= src_acc + 25'(`TFMT_SRC_HZ) - 25'(`TFMT_CLK_HZ);
      src_tick <= 1'b1;
    end else begin
      src_acc <= src_acc + 25'(`TFMT_SRC_HZ);
      src_tick <= 1'b0;
    end
  end
  // (R9) preset counter chain, 1600 then halved to 800
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      div <= 16'h0;
      c1600 <= 1'b0;
      c800 <= 1'b0;
    end else begin
      c1600 <= 1'b0;
      if (src_tick) begin
        if (div == 16'h0) begin
          div <= preset;
          c1600 <= 1'b1;
          c800 <= ~c800;
        end else begin
          div <= div - 16'h1;
        end
      end
    end
  end
  logic c800_d;
  logic tick800;
  assign tick800 = c1600 & c800 & ~c800_d;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      c800_d <= 1'b0;
      timer_tick <= 1'b0;
      write_strobe <= 1'b0;
    end else begin
      c800_d <= c800;
      // (R11) timer from 800 clock, (R10) always running
      timer_tick <= tick800;
      // (R10) strobe only while write gate set
      write_strobe <= ctrl[`TFMT_C_WRITE_GATE_ENABLE] &
        (ctrl[`TFMT_C_PE] ? c1600 : tick800);
    end
  end

  // =====================================================
  // read head synchronisers and edge detect
  logic [8:0] rh_s1;
  logic [8:0] rh_s2;
  logic [8:0] rh_d;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rh_s1 <= 9'h0;
      rh_s2 <= 9'h0;
      rh_d <= 9'h0;
    end else begin
      rh_s1 <= read_head;
      rh_s2 <= rh_s1;
      rh_d <= rh_s2;
    end
  end
  logic [8:0] fall;
  logic [8:0] rise;
  assign fall = rh_d & ~rh_s2;
  assign rise = ~rh_d & rh_s2;

  // =====================================================
  // activity control
  logic rgate;
  assign rgate = ctrl[`TFMT_C_RGATE];
  logic lock_enable;
  logic locked;
  logic no_data;
  logic [3:0] trans;
  logic [15:0] lwait;
  logic [15:0] idle;
  logic act;
  assign act = (fall[2] | rise[2] | fall[8] | rise[8]);
  // (R12) watch ch2 and parity once gated, (R13) lock sequence
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      trans <= 4'h0;
      lwait <= 16'h0;
      lock_enable <= 1'b0;
      locked <= 1'b0;
    end else if (!rgate) begin
      trans <= 4'h0;
      lwait <= 16'h0;
      lock_enable <= 1'b0;
      locked <= 1'b0;
    end else if (!lock_enable) begin
      if (act) trans <= trans + 4'h1;
      lock_enable <= act & (trans == `TFMT_LOCK_ENABLE_TRANS - 4'h1);
    end else if (!locked) begin
      lwait <= lwait + 16'h1;
      locked <= (lwait == `TFMT_LOCKED_WAIT);
    end
  end
  // (R15) no data after both monitored channels idle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      idle <= 16'h0;
      no_data <= 1'b0;
    end else if (!rgate || !locked || act) begin
      idle <= 16'h0;
      no_data <= 1'b0;
    end else if (idle != `TFMT_NODATA_WAIT) begin
      idle <= idle + 16'h1;
    end else begin
      no_data <= 1'b1;
    end
  end

  // =====================================================
  // recovered clock: follow char clock, then parity, then ch2
  logic [4:0] d24;
  logic rclk;
  logic [8:0] drop;
  logic ref_edge;
  // (R20) tracking source selection
  assign ref_edge = !locked ? c1600 :
    (!drop[8] ? (fall[8] | rise[8]) : (fall[2] | rise[2]));
  // (R21) shared divide-by-24 stage
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      d24 <= 5'h0;
      rclk <= 1'b0;
    end else begin
      rclk <= (d24 == `TFMT_DIV24);
      // only late edges realign; mid-cell phase edges would stall it
      if ((ref_edge && d24 > `TFMT_DIV24_HALF) || d24 == `TFMT_DIV24)
        d24 <= 5'h0;
      else d24 <= d24 + 5'h1;
    end
  end

  // =====================================================
  // per-channel preamble/sync machines
  tfmt_chan_t st [9];
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 9; i++) st[i] <= TFMT_S0;
      drop <= 9'h0;
      shift_in <= 9'h0;
    end else begin
      for (int i = 0; i < 9; i++) begin
        shift_in[i] <= 1'b0;
        if (!lock_enable) begin
          // (R23) disabled channel back to state zero
          st[i] <= TFMT_S0;
          drop[i] <= 1'b0;
        end else if (drop[i]) begin
          // (R17) (R19) force-feed until disabled
          shift_in[i] <= rclk;
        end else begin
          unique case (st[i])
            // (R16) falling edge marks zero bit
            TFMT_S0: begin
              if (fall[i]) st[i] <= TFMT_S1;
              // (R14) unlocked at locked drops out
              else if (locked) drop[i] <= 1'b1;
            end
            // (R18) await first one transition
            TFMT_S1: begin
              if (rise[i]) st[i] <= TFMT_S2;
              else if (no_data) drop[i] <= 1'b1;
            end
            // (R18) shift per major transition
            TFMT_S2: begin
              shift_in[i] <= rise[i];
              if (no_data) drop[i] <= 1'b1;
            end
          endcase
        end
      end
    end
  end

  // =====================================================
  // status table, read data, bus read mux
  logic [8:0] rdin;
  logic chk_err;
  // (R22) dropout pattern decode table
  function automatic tfmt_pe_stat_t pe_stat(input logic [8:0] d);
    tfmt_pe_stat_t s;
    s = '0;
    s.single_drop = ($countones(d) == 1);
    s.multi_drop = ($countones(d) > 1) && (d != 9'h1FF);
    s.all_drop = (d == 9'h1FF);
    s.file_mark = (d == 9'h1B2);
    s.id_burst = (d == 9'h0FF);
    return s;
  endfunction : pe_stat
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdin <= 9'h0;
      chk_err <= 1'b0;
    end else begin
      rdin <= rh_s2;
      // (R8) parity checked on bus move
      if (acc & read & (address == `TFMT_A_RDATA)) begin
        // regenerated parity over the data byte must match bit 8
        chk_err <= (par9({1'b0, rdin[7:0]}) != rdin[8]);
      end
    end
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      readdata <= 32'h0;
    end else if (read & ~busy) begin
      // loaded as waitrequest drops, so it stands at the taking edge
      unique case (address)
        // (R6) NRZ upper zero, (R7) PE parity fill
        `TFMT_A_RDATA: readdata <= ctrl[`TFMT_C_PE] ?
          {16'h0, {8{rdin[8]}}, rdin[7:0]} : {23'h0, rdin};
        `TFMT_A_STAT: readdata <= {20'h0, pe_stat(drop),
          no_data, locked, lock_enable, chk_err, 3'h0};
        `TFMT_A_RDIN: readdata <= {23'h0, drop};
        `TFMT_A_CTRL: readdata <= {29'h0, ctrl};
        `TFMT_A_UNIT: readdata <= {29'h0, unit};
        `TFMT_A_CMD: readdata <= {24'h0, drive_command};
        `TFMT_A_WDATA: readdata <= {23'h0, write_char.par,
          write_char.data};
        `TFMT_A_PRESET: readdata <= {16'h0, preset};
        default: readdata <= 32'h0;
      endcase
    end
  end

  // =====================================================
  // checks
  // (R4) exactly one select active
  a_select_onehot: assert property (@(posedge clock) disable iff (!rst_n)
    $past(rst_n) |-> $onehot(drive_select)) // (R4)
    else $error("drive select not one-hot");
  a_strobe_gate: assert property (@(posedge clock) disable iff (!rst_n)
    write_strobe |-> $past(ctrl[`TFMT_C_WRITE_GATE_ENABLE])) // (R10)
    else $error("write strobe without gate");
  a_parity_load: assert property (@(posedge clock) disable iff (!rst_n)
    wr_data |=> write_char.par == par9($past(writedata[8:0]))) // (R2)
    else $error("write parity wrong");
  a_locked_order: assert property (@(posedge clock) disable iff (!rst_n)
    locked |-> lock_enable) // (R13)
    else $error("locked without lock enable");
  a_drop_unlocked: assert property (@(posedge clock) disable iff (!rst_n)
    (lock_enable && locked && st[0] == TFMT_S0 && !drop[0] && !fall[0])
    |=> drop[0]) // (R14)
    else $error("unlocked channel kept alive");
  a_gate_off_clear: assert property (@(posedge clock) disable iff (!rst_n)
    !rgate |=> !lock_enable && !locked) // (R12)
    else $error("lock held without read gate");
  a_div_bound: assert property (@(posedge clock) disable iff (!rst_n)
    d24 <= `TFMT_DIV24) // (R21)
    else $error("divider out of range");
  a_nodata_lock: assert property (@(posedge clock) disable iff (!rst_n)
    no_data |-> locked) // (R15)
    else $error("no data before lock");
endmodule : tfmt_core

//--- sim/tfmt_drive_model.sv
// tape drive read head model: phase-encoded flux on nine channels
// assumes the bench raises active only while a record passes the head
`timescale 1ns/1ps
module tfmt_drive_model (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic active,
  input wire logic [8:0] dead,
  output logic [8:0] read_head
);
  logic [3:0] ph;
  logic [7:0] nt;
  // ==========================================
  // flux generator
  // dead channels and idle tape carry no flux, so lines stay flat
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ph <= 4'h0;
      nt <= 8'h00;
      read_head <= 9'h1FF;
    end else if (active) begin
      ph <= (ph == 4'hB) ? 4'h0 : ph + 4'h1;
      if (ph == 4'hB) begin
        nt <= nt + 8'h01;
        // zeros preamble, one held slot marks the sync one
        if (nt != 8'h64) read_head <= read_head ^ ~dead;
      end
    end
  end
endmodule : tfmt_drive_model

//--- sim/tape_format_read_write_logic_tb.sv
// bench for the tape format block: Avalon-MM register sequences
// assumes the drive model on the head lines, one 25 MHz clock
`timescale 1ns/1ps
module tape_format_read_write_logic_tb;
  import tfmt_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest;
  logic [8:0] read_head;
  logic [7:0] drive_select;
  logic [7:0] drive_command;
  tfmt_wchar_t write_char;
  logic [8:0] shift_in;
  logic write_strobe;
  logic timer_tick;
  logic active = 1'b0;
  logic [8:0] dead = 9'h000;
  logic [31:0] q;
  int fails = 0;
  int num_checks = 0;
  int ns = 0;
  int nt = 0;
  int nsh = 0;
  int nsh1 = 0;
  int s0;
  int t0;
  tfmt_core dut_u (.clock(clock), .rst_n(rst_n), .address(address),
    .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest),
    .read_head(read_head), .drive_select(drive_select),
    .drive_command(drive_command), .write_char(write_char),
    .shift_in(shift_in), .write_strobe(write_strobe),
    .timer_tick(timer_tick));
  tfmt_drive_model drv_u (.clock(clock), .rst_n(rst_n), .active(active),
    .dead(dead), .read_head(read_head));
  initial begin
    forever #20 clock = ~clock;
  end
  always @(posedge clock) begin
    if (write_strobe === 1'b1) ns++;
    if (timer_tick === 1'b1) nt++;
    if (shift_in[0] === 1'b1) nsh++;
    if (shift_in[1] === 1'b1) nsh1++;
  end
  // ==========================================
  // shared tasks
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // request held until the edge that sees waitrequest low
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    address <= a;
    writedata <= d;
    read <= ~wr;
    write <= wr;
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (waitrequest !== 1'b0) begin
      fails++;
      end_sim();
    end
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clock);
  endtask : bus
  task automatic wait_bit(input int b);
    int n;
    n = 0;
    do begin
      bus(1'b0, 4'h6, 32'h0);
      n++;
    end while (q[b] !== 1'b1 && n < 2000);
    chk("status bit", 32'h1, {31'h0, q[b]});
    if (q[b] !== 1'b1) end_sim();
  endtask : wait_bit
  task automatic idle(input int n);
    repeat (n) @(posedge clock);
  endtask : idle
  task automatic do_reset;
    rst_n <= 1'b0;
    idle(16);
    rst_n <= 1'b1;
    // select register settles one edge after release
    idle(2);
  endtask : do_reset
  // ==========================================
  // scenarios
  initial begin
    do_reset();
    chk("select", 32'h1, {24'h0, drive_select});
    bus(1'b0, 4'h9, 32'h0);
    chk("preset", 32'h9, q);
    bus(1'b0, 4'h6, 32'h0);
    chk("status", 32'h0, q);
    bus(1'b1, 4'h0, 32'h0A5);
    chk("wchar", {23'h0, ~^9'h0A5, 8'hA5}, {22'h0, write_char});
    bus(1'b1, 4'h0, 32'h0B7);
    chk("wchar", {23'h0, ~^9'h0B7, 8'hB7}, {22'h0, write_char});
    bus(1'b1, 4'h1, 32'h1);
    chk("raw par", {22'h0, 2'b01, 8'hB7}, {22'h0, write_char});
    bus(1'b1, 4'h1, 32'h0);
    chk("raw par", {22'h0, 2'b00, 8'hB7}, {22'h0, write_char});
    for (int u = 0; u < 8; u++) begin
      bus(1'b1, 4'h2, u);
      // select follows the unit register one edge later
      idle(1);
      chk("select", 32'h1 << u, {24'h0, drive_select});
    end
    bus(1'b1, 4'h3, 32'h5A);
    chk("command", 32'h5A, {24'h0, drive_command});
    bus(1'b1, 4'h8, 32'hFF);
    bus(1'b0, 4'h8, 32'h0);
    chk("unmapped", 32'h0, q);
    s0 = ns;
    t0 = nt;
    idle(4000);
    chk("strobe off", s0, ns);
    // preset 9: one 800 tick per 20 source ticks, about 69.4 clocks
    chk("timer", 32'h1, {31'h0, (nt - t0) inside {[56:59]}});
    bus(1'b1, 4'h4, 32'h1);
    s0 = ns;
    idle(4000);
    chk("strobe on", 32'h1, {31'h0, ns > s0});
    chk("gate", 32'h1, {31'h0, write_char.gate});
    bus(1'b1, 4'h4, 32'h0);
    bus(1'b0, 4'h5, 32'h0);
    chk("nrz read", 32'h1FF, q);
    bus(1'b1, 4'h4, 32'h4);
    bus(1'b0, 4'h5, 32'h0);
    chk("pe read", 32'hFFFF, q);
    bus(1'b0, 4'h6, 32'h0);
    chk("parity ok", 32'h0, {31'h0, q[3]});
    // ch0 dead: never locks, so it must drop out at locked
    dead <= 9'h001;
    bus(1'b1, 4'h4, 32'h6);
    active <= 1'b1;
    wait_bit(4);
    wait_bit(5);
    bus(1'b0, 4'h7, 32'h0);
    chk("drops", 32'h001, {23'h0, q[8:0]});
    bus(1'b0, 4'h6, 32'h0);
    chk("single", 32'h1, {31'h0, q[11]});
    s0 = nsh;
    t0 = nsh1;
    idle(100);
    chk("stream", 32'h1, {31'h0, nsh > s0});
    chk("data shift", 32'h1, {31'h0, nsh1 > t0});
    active <= 1'b0;
    wait_bit(6);
    idle(20);
    bus(1'b0, 4'h7, 32'h0);
    chk("drops", 32'h1FF, {23'h0, q[8:0]});
    bus(1'b0, 4'h6, 32'h0);
    chk("all drop", 32'h1, {31'h0, q[9]});
    s0 = nsh;
    idle(50);
    chk("force feed", 32'h1, {31'h0, nsh > s0});
    bus(1'b1, 4'h4, 32'h0);
    idle(10);
    s0 = nsh;
    idle(50);
    chk("disabled", s0, nsh);
    s0 = ns;
    bus(1'b1, 4'h4, 32'h7);
    active <= 1'b1;
    wait_bit(4);
    chk("pe strobe", 32'h1, {31'h0, ns > s0});
    do_reset();
    active <= 1'b0;
    bus(1'b0, 4'h4, 32'h0);
    chk("ctrl", 32'h0, q);
    bus(1'b0, 4'h6, 32'h0);
    chk("status", 32'h0, q);
    bus(1'b0, 4'h7, 32'h0);
    chk("drops", 32'h0, q);
    // one flux step on seven lines leaves two ones: even, a parity error
    dead <= 9'h003;
    active <= 1'b1;
    idle(13);
    active <= 1'b0;
    idle(4);
    bus(1'b0, 4'h5, 32'h0);
    chk("nrz odd", 32'h003, q);
    bus(1'b0, 4'h6, 32'h0);
    chk("parity err", 32'h1, {31'h0, q[3]});
    end_sim();
  end
endmodule : tape_format_read_write_logic_tb
